//--- rtl/hbdc_pkg.sv
package hbdc_pkg;

   // Register byte addresses
   localparam logic [7:0] HBDC_CTRL_OFFS      = 8'h00;
   localparam logic [7:0] HBDC_MON_OFFS       = 8'h04;

   // Control/status field positions
   localparam int HBDC_BIT_EN      = 0;
   localparam int HBDC_BIT_PWM_SEL = 1;
   localparam int HBDC_BIT_LEFT    = 2;
   localparam int HBDC_BIT_RIGHT   = 3;
   localparam int HBDC_BIT_DIR     = 4;
   localparam int HBDC_BIT_OC      = 5;
   localparam int HBDC_BIT_OT      = 6;
   localparam int HBDC_BIT_IE      = 7;

   localparam logic [7:0] HBDC_CTRL_RESET     = 8'h00;

   // Overcurrent turn-off delay
   localparam int HBDC_CLK_HZ        = 50_000_000;
   localparam int HBDC_OC_DELAY_NS   = 1000;
   localparam int HBDC_OC_DELAY_CYC  =
      (HBDC_OC_DELAY_NS * (HBDC_CLK_HZ / 1_000_000)) / 1000;
   localparam logic [7:0] HBDC_OC_CNT_MAX = 8'(HBDC_OC_DELAY_CYC);

   // AXI responses
   localparam logic [1:0] HBDC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] HBDC_RESP_SLVERR = 2'h2;

   // Drive modes
   typedef enum logic [4:0] {
      HBDC_M_DIRECT = 5'b0_0001,
      HBDC_M_UPBRK  = 5'b0_0010,
      HBDC_M_DNBRK  = 5'b0_0100,
      HBDC_M_SYMM   = 5'b0_1000,
      HBDC_M_DUAL   = 5'b1_0000
   } hbdc_mode_t;

endpackage : hbdc_pkg

//--- rtl/hbdc_leg_if.sv
`timescale 1ns/1ps
interface hbdc_leg_if;
   logic want_high;
   logic want_low;
   logic high_gate;
   logic low_gate;
   modport ctrl (output want_high, output want_low,
                 input high_gate, input low_gate);
   modport leg  (input want_high, input want_low,
                 output high_gate, output low_gate);
endinterface : hbdc_leg_if

//--- rtl/hbdc_leg.sv
`timescale 1ns/1ps
// One half-bridge: break-before-make gate sequencing
module hbdc_leg
   import hbdc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // Gate sense and leg commands
   input  wire logic high_sense,
   input  wire logic low_sense,
   hbdc_leg_if.leg   lg
);
   typedef struct packed {
      logic high;
      logic low;
   } hbdc_leg_st_t;

   hbdc_leg_st_t st_reg;
   hbdc_leg_st_t st_next;

   always_comb begin
      st_next = st_reg;
      // Turn-off immediate; turn-on only once the opposite gate senses off
      if (!lg.want_high) st_next.high = 1'b0;
      if (!lg.want_low)  st_next.low  = 1'b0;
      if (lg.want_high && !lg.want_low && !st_reg.low && !low_sense) begin
         st_next.high = 1'b1;
      end
      if (lg.want_low && !lg.want_high && !st_reg.high && !high_sense) begin
         st_next.low = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign lg.high_gate = st_reg.high;
   assign lg.low_gate  = st_reg.low;

endmodule : hbdc_leg

//--- rtl/hbdc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Enable low forces all gates off
// - Enable bit resets to zero
// - Overcurrent flag is OR of four detectors
// - Overcurrent flag read-only, cleared by enable clear
// - Tripped transistor off after delay; blocks turn-on
// - Overcurrent rising edge requests interrupt if enabled
// - Overtemperature sets flag, forces all gates off
// - Thermal rising edge interrupts; cleared by enable clear
// - Enabling interrupt with fault pending requests immediately
// - Interrupt pending until enable bit cleared
// - Fault logic independent of output state
// - Direct mode: control bits select on transistors
// - Up-brake: PWM low brakes high sides
// - Down-brake: PWM low brakes low sides
// - Symmetrical: PWM xor direction selects polarity
// - Dual mode: left follows A, right B
// - Direction latched on driving PWM rising edge
// - High and low of a leg never together
// - Eight control/status bits in one register
module hbdc_top
   import hbdc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // PWM lines and detectors (asynchronous)
   input  wire logic        pwm_line_a,
   input  wire logic        pwm_line_b,
   input  wire logic [3:0]  per_transistor_overcurrent,
   input  wire logic        over_temperature,
   input  wire logic [3:0]  gate_sense,
   // Gate commands and interrupt
   output logic             left_high_gate,
   output logic             left_low_gate,
   output logic             right_high_gate,
   output logic             right_low_gate,
   output logic             bridge_irq
);
   // Detector and gate-sense order: left high, left low, right high, right low

   typedef struct packed {
      logic [1:0] s_pa;
      logic [1:0] s_pb;
      logic [1:0] s_ot;
      logic [3:0] s_oc1;
      logic [3:0] s_oc;
      logic [3:0] s_gs1;
      logic [3:0] s_gs;
      logic       pa_d;
      logic       pb_d;
      logic       en;
      logic       pwm_sel;
      logic       left_bit;
      logic       right_bit;
      logic       dir_wr;
      logic       dir_a;
      logic       dir_b;
      logic       oc_flag;
      logic       ot_flag;
      logic       irq_en;
      logic       irq;
      logic [3:0] oc_kill;
      logic [7:0] oc_cnt;
      logic [3:0] gates;
      logic       aw_got;
      logic       w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic       aw_rdy;
      logic       w_rdy;
      logic       ar_rdy;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } hbdc_st_t;

   hbdc_st_t st_reg;
   hbdc_st_t st_next;

   hbdc_leg_if leg_l ();
   hbdc_leg_if leg_r ();

   hbdc_mode_t mode;
   logic [3:0] want;
   logic [7:0] csr;
   logic       pa;
   logic       pb;
   logic       pa_rise;
   logic       pb_rise;
   logic       oc_any;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and gate requests
   assign pa      = st_reg.s_pa[1];
   assign pb      = st_reg.s_pb[1];
   assign pa_rise = pa && !st_reg.pa_d;
   assign pb_rise = pb && !st_reg.pb_d;
   assign oc_any  = |st_reg.s_oc;

   assign csr = {st_reg.irq_en, st_reg.ot_flag, st_reg.oc_flag,
                 st_reg.dir_wr, st_reg.right_bit, st_reg.left_bit,
                 st_reg.pwm_sel, st_reg.en};

   always_comb begin
      if (!st_reg.pwm_sel) begin
         mode = HBDC_M_DIRECT;
      end else begin
         case ({st_reg.left_bit, st_reg.right_bit})
            2'b00:   mode = HBDC_M_UPBRK;
            2'b01:   mode = HBDC_M_DNBRK;
            2'b10:   mode = HBDC_M_SYMM;
            default: mode = HBDC_M_DUAL;
         endcase
      end
   end

   // want = {left high, left low, right high, right low}
   always_comb begin
      want = 4'h0;
      case (mode)
         HBDC_M_DIRECT: begin
            want = {st_reg.left_bit, !st_reg.left_bit,
                    st_reg.right_bit, !st_reg.right_bit};
         end
         HBDC_M_UPBRK: begin
            if (!pa) want = 4'b1010;
            else if (!st_reg.dir_a) want = 4'b1001;
            else want = 4'b0110;
         end
         HBDC_M_DNBRK: begin
            if (!pa) want = 4'b0101;
            else if (!st_reg.dir_a) want = 4'b1001;
            else want = 4'b0110;
         end
         HBDC_M_SYMM: begin
            if (pa != st_reg.dir_a) want = 4'b1001;
            else want = 4'b0110;
         end
         HBDC_M_DUAL: begin
            want = {pa, !pa, pb, !pb};
         end
         default: want = 4'h0;
      endcase
      // Faults and enable applied last
      if (!st_reg.en || st_reg.ot_flag) want = 4'h0;
      want = want & ~st_reg.oc_kill;
   end

   assign leg_l.want_high = want[3];
   assign leg_l.want_low  = want[2];
   assign leg_r.want_high = want[1];
   assign leg_r.want_low  = want[0];

   hbdc_leg u_leg_l (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .high_sense (st_reg.s_gs[3]),
      .low_sense  (st_reg.s_gs[2]),
      .lg         (leg_l.leg)
   );

   hbdc_leg u_leg_r (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .high_sense (st_reg.s_gs[1]),
      .low_sense  (st_reg.s_gs[0]),
      .lg         (leg_r.leg)
   );

   ////////////////////////////////////////////////////////////////////////
   // State update
   always_comb begin
      logic       wr_fire;
      logic       rd_fire;
      logic [7:0] wb;
      logic       hit_ctrl;
      logic       set_oc;
      logic       set_ot;
      wr_fire  = 1'b0;
      rd_fire  = 1'b0;
      wb       = 8'h00;
      hit_ctrl = 1'b0;
      set_oc   = 1'b0;
      set_ot   = 1'b0;
      st_next  = st_reg;

      // Two-flop synchronisers
      st_next.s_pa  = {st_reg.s_pa[0], pwm_line_a};
      st_next.s_pb  = {st_reg.s_pb[0], pwm_line_b};
      st_next.s_ot  = {st_reg.s_ot[0], over_temperature};
      st_next.s_oc1 = per_transistor_overcurrent;
      st_next.s_oc  = st_reg.s_oc1;
      st_next.s_gs1 = gate_sense;
      st_next.s_gs  = st_reg.s_gs1;
      st_next.pa_d  = pa;
      st_next.pb_d  = pb;
      st_next.gates = {leg_l.high_gate, leg_l.low_gate,
                       leg_r.high_gate, leg_r.low_gate};

      // Direction latched on the rising edge of each PWM line
      if (pa_rise) st_next.dir_a = st_reg.dir_wr;
      if (pb_rise) st_next.dir_b = st_reg.dir_wr;

      // AXI write channel
      if (s_axi_awvalid && st_reg.aw_rdy) begin
         st_next.aw_got  = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.w_rdy) begin
         st_next.w_got  = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         wr_fire         = 1'b1;
         st_next.aw_got  = 1'b0;
         st_next.w_got   = 1'b0;
         st_next.bvalid  = 1'b1;
         hit_ctrl = ({st_reg.aw_addr[7:2], 2'b00} == HBDC_CTRL_OFFS);
         st_next.bresp = (hit_ctrl || {st_reg.aw_addr[7:2], 2'b00}
                          == HBDC_MON_OFFS) ? HBDC_RESP_OKAY
                                            : HBDC_RESP_SLVERR;
      end
      if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;

      if (wr_fire && hit_ctrl && st_reg.w_strb[0]) begin
         wb = st_reg.w_data[7:0];
         st_next.en        = wb[HBDC_BIT_EN];
         st_next.pwm_sel   = wb[HBDC_BIT_PWM_SEL];
         st_next.left_bit  = wb[HBDC_BIT_LEFT];
         st_next.right_bit = wb[HBDC_BIT_RIGHT];
         st_next.dir_wr    = wb[HBDC_BIT_DIR];
         st_next.irq_en    = wb[HBDC_BIT_IE];
         // A pending fault forbids switching the bridge on
         if ((st_reg.oc_flag || st_reg.ot_flag) && wb[HBDC_BIT_EN]) begin
            st_next.en = st_reg.en;
         end
         // Enabling the interrupt with a fault pending
         if (wb[HBDC_BIT_IE] && (st_reg.oc_flag || st_reg.ot_flag)) begin
            st_next.irq = 1'b1;
         end
      end

      // Fault detection, regardless of output state
      set_oc = st_reg.en && oc_any && !st_reg.oc_flag;
      set_ot = st_reg.en && st_reg.s_ot[1] && !st_reg.ot_flag;
      if (set_oc) st_next.oc_flag = 1'b1;
      if (set_ot) st_next.ot_flag = 1'b1;
      if ((set_oc || set_ot) && st_reg.irq_en) begin
         st_next.irq = 1'b1;
      end

      // Turn tripped transistors off after the delay
      if (st_reg.oc_flag && st_reg.oc_cnt != HBDC_OC_CNT_MAX) begin
         st_next.oc_cnt = st_reg.oc_cnt + 8'h01;
      end
      if (st_reg.oc_flag && st_reg.oc_cnt == HBDC_OC_CNT_MAX) begin
         st_next.oc_kill = st_reg.oc_kill | st_reg.s_oc;
      end

      // Clearing enable clears flags, kill mask and interrupt
      if (!st_next.en) begin
         st_next.oc_flag = 1'b0;
         st_next.ot_flag = 1'b0;
         st_next.irq     = 1'b0;
         st_next.oc_kill = 4'h0;
         st_next.oc_cnt  = 8'h00;
      end

      // AXI read channel
      if (s_axi_arvalid && st_reg.ar_rdy) begin
         rd_fire = 1'b1;
      end
      if (rd_fire) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = HBDC_RESP_OKAY;
         st_next.rdata  = 32'h0000_0000;
         if ({s_axi_araddr[7:2], 2'b00} == HBDC_CTRL_OFFS) begin
            st_next.rdata[7:0] = csr;
         end else if ({s_axi_araddr[7:2], 2'b00} == HBDC_MON_OFFS) begin
            st_next.rdata[13:0] = {st_reg.dir_b, st_reg.dir_a,
                                   st_reg.oc_kill, st_reg.gates,
                                   st_reg.s_oc};
         end else begin
            st_next.rresp = HBDC_RESP_SLVERR;
         end
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // Ready outputs registered; low for one cycle after reset
      st_next.aw_rdy = !st_next.aw_got;
      st_next.w_rdy  = !st_next.w_got;
      st_next.ar_rdy = !st_next.rvalid;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready   = st_reg.aw_rdy;
   assign s_axi_wready    = st_reg.w_rdy;
   assign s_axi_bvalid    = st_reg.bvalid;
   assign s_axi_bresp     = st_reg.bresp;
   assign s_axi_arready   = st_reg.ar_rdy;
   assign s_axi_rvalid    = st_reg.rvalid;
   assign s_axi_rdata     = st_reg.rdata;
   assign s_axi_rresp     = st_reg.rresp;
   assign left_high_gate  = st_reg.gates[3];
   assign left_low_gate   = st_reg.gates[2];
   assign right_high_gate = st_reg.gates[1];
   assign right_low_gate  = st_reg.gates[0];
   assign bridge_irq      = st_reg.irq;

endmodule : hbdc_top

//--- dv/hbdc_load_model.sv
`timescale 1ns/1ps
// Power stage and load: sense lags gates, a short trips an on device
module hbdc_load_model (
   // Clock
   input  wire logic       clk_sys,
   // Gate commands {lh, ll, rh, rl} and shorts requested by the bench
   input  wire logic [3:0] gates,
   input  wire logic [3:0] short_req,
   // Feedback to the controller
   output logic      [3:0] gate_sense,
   output logic      [3:0] per_transistor_overcurrent
);
   logic [3:0] sense_d;
   initial begin
      sense_d = 4'h0;
      gate_sense = 4'h0;
   end
   // Gate voltage settles two cycles after the command
   always @(posedge clk_sys) begin
      sense_d <= gates;
      gate_sense <= sense_d;
   end
   // Current only flows through a shorted device while it is on
   assign per_transistor_overcurrent = short_req & gate_sense;
endmodule : hbdc_load_model

//--- dv/hbdc_asserts.sv
`timescale 1ns/1ps
module hbdc_asserts (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        resetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Bridge
   input wire logic        over_temperature,
   input wire logic        left_high_gate,
   input wire logic        left_low_gate,
   input wire logic        right_high_gate,
   input wire logic        right_low_gate,
   input wire logic        bridge_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////
   property p_left_excl;
      !(left_high_gate && left_low_gate);
   endproperty
   a_left_excl: assert property (p_left_excl)
      else $error("left leg both on");
   property p_right_excl;
      !(right_high_gate && right_low_gate);
   endproperty
   a_right_excl: assert property (p_right_excl)
      else $error("right leg both on");
   property p_left_gap;
      $rose(left_high_gate) |-> !$past(left_low_gate);
   endproperty
   a_left_gap: assert property (p_left_gap)
      else $error("left high on without gap");
   property p_right_gap;
      $rose(right_low_gate) |-> !$past(right_high_gate);
   endproperty
   a_right_gap: assert property (p_right_gap)
      else $error("right low on without gap");
   property p_ot_off;
      over_temperature [*3] |-> ##[0:8] !(left_high_gate || left_low_gate
         || right_high_gate || right_low_gate);
   endproperty
   a_ot_off: assert property (p_ot_off)
      else $error("gates on during overtemperature");
   property p_b_after;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after)
      else $error("write response late");
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop)
      else $error("write response repeated");
   property p_r_after;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_after: assert property (p_r_after)
      else $error("read data late");
   property p_r_drop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_drop: assert property (p_r_drop)
      else $error("read data repeated");
   property p_irq_fall;
      $fell(bridge_irq) |-> s_axi_bvalid || $past(s_axi_bvalid)
         || $past(s_axi_bvalid, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt cleared without a write");
endmodule : hbdc_asserts
////////////////////////////////////////////////////////////////////////////
bind hbdc_top hbdc_asserts i_asserts (
   .clk_sys(clk_sys), .resetn(resetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .over_temperature(over_temperature),
   .left_high_gate(left_high_gate), .left_low_gate(left_low_gate),
   .right_high_gate(right_high_gate), .right_low_gate(right_low_gate),
   .bridge_irq(bridge_irq));

//--- dv/hbdc_tb_top.sv
`timescale 1ns/1ps
module hbdc_tb_top
   import hbdc_pkg::*;
;
   logic        clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready;
   logic        pa, pb, ot, awready, wready, bvalid, arready, rvalid, irq;
   logic        lh, ll, rh, rl;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  short_req, sense, oc, gates;
   int          error_cnt, cmp_count;
   assign gates = {lh, ll, rh, rl};
   hbdc_top i_dut (.clk_sys(clk_sys), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pwm_line_a(pa), .pwm_line_b(pb),
      .per_transistor_overcurrent(oc), .over_temperature(ot),
      .gate_sense(sense), .left_high_gate(lh), .left_low_gate(ll),
      .right_high_gate(rh), .right_low_gate(rl), .bridge_irq(irq));
   hbdc_load_model i_load (.clk_sys(clk_sys), .gates(gates),
      .short_req(short_req), .gate_sense(sense),
      .per_transistor_overcurrent(oc));
   ////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task chk_gates(input logic [3:0] e);
      chk(32'(gates), 32'(e));
   endtask : chk_gates
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'bxx;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      d = 32'hx;
      r = 2'bxx;
      araddr <= a;
      arvalid <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask : rd
   task w(input logic [31:0] d);
      logic [1:0] r;
      wr(HBDC_CTRL_OFFS, d, r);
      chk(32'(r), 32'(HBDC_RESP_OKAY));
   endtask : w
   task rdc(input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(HBDC_CTRL_OFFS, d, r);
      chk(d & 32'h0000_00ff, {24'h0, e});
   endtask : rdc
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   // Control word: m is {left, right}
   function automatic logic [31:0] cw(input logic en, sel,
      input logic [1:0] m, input logic dir, ie);
      return {24'h0, ie, 2'b00, dir, m[0], m[1], sel, en};
   endfunction : cw
   function automatic logic [3:0] ex(input logic [1:0] m,
      input logic d, a, b);
      case (m)
         2'd0: return a ? (d ? 4'h6 : 4'h9) : 4'ha;
         2'd1: return a ? (d ? 4'h6 : 4'h9) : 4'h5;
         2'd2: return (a != d) ? 4'h9 : 4'h6;
         default: return {a, ~a, b, ~b};
      endcase
   endfunction : ex
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #1_000_000;
      error_cnt++;
      finish_test();
   end
   initial begin
      logic [1:0]  mm, r;
      logic [31:0] d;
      {resetn, awvalid, wvalid, arvalid} = 4'h0;
      // Response ready held high so back-to-back calls never re-drive it
      {bready, rready} = 2'b11;
      {pa, pb, ot, awaddr, araddr, wdata, short_req} = '0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      wt(1);
      rdc(8'h00);
      chk_gates(4'h0);
      w(cw(1'b0, 1'b0, 2'b11, 1'b0, 1'b0) | 32'h0000_0060);
      wt(12);
      chk_gates(4'h0);
      rdc(8'h0c);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         mm = 2'(k);
         pa <= mm[0];
         w(cw(1'b1, 1'b0, mm, 1'b0, 1'b0));
         wt(16);
         chk_gates({mm[1], ~mm[1], mm[0], ~mm[0]});
      end
      $display("test direct done");
      for (int k = 0; k < 8; k++) begin
         mm = 2'(k >> 1);
         w(cw(1'b1, 1'b1, mm, k[0], 1'b0));
         pa <= 1'b0;
         wt(8);
         pa <= 1'b1;
         wt(16);
         chk_gates(ex(mm, k[0], 1'b1, 1'b0));
         pa <= 1'b0;
         pb <= 1'b1;
         wt(16);
         chk_gates(ex(mm, k[0], 1'b0, 1'b1));
         pb <= 1'b0;
      end
      $display("test pwm modes done");
      w(cw(1'b1, 1'b1, 2'b10, 1'b0, 1'b0));
      wt(8);
      pa <= 1'b1;
      wt(16);
      w(cw(1'b1, 1'b1, 2'b10, 1'b1, 1'b0));
      wt(16);
      chk_gates(4'h9);
      pa <= 1'b0;
      wt(8);
      pa <= 1'b1;
      wt(16);
      chk_gates(4'h6);
      $display("test direction done");
      w(cw(1'b1, 1'b0, 2'b10, 1'b0, 1'b1));
      wt(16);
      short_req <= 4'h8;
      wt(80);
      rdc(8'ha5);
      chk(32'(irq), 32'h1);
      chk_gates(4'h1);
      w(cw(1'b1, 1'b0, 2'b10, 1'b0, 1'b1));
      rdc(8'ha5);
      w(cw(1'b0, 1'b0, 2'b10, 1'b0, 1'b1));
      wt(4);
      rdc(8'h84);
      chk(32'(irq), 32'h0);
      w(cw(1'b1, 1'b0, 2'b10, 1'b0, 1'b0));
      wt(80);
      rdc(8'h25);
      chk(32'(irq), 32'h0);
      w(cw(1'b1, 1'b0, 2'b10, 1'b0, 1'b1));
      wt(4);
      chk(32'(irq), 32'h1);
      short_req <= 4'h0;
      w(32'h0);
      $display("test overcurrent done");
      w(cw(1'b1, 1'b0, 2'b01, 1'b0, 1'b1));
      wt(16);
      ot <= 1'b1;
      wt(20);
      rdc(8'hc9);
      chk_gates(4'h0);
      chk(32'(irq), 32'h1);
      ot <= 1'b0;
      wt(10);
      rdc(8'hc9);
      w(32'h0);
      wt(4);
      rdc(8'h00);
      chk(32'(irq), 32'h0);
      $display("test thermal done");
      rd(8'h08, d, r);
      chk(32'(r), 32'(HBDC_RESP_SLVERR));
      wr(8'h08, 32'h0000_00ff, r);
      chk(32'(r), 32'(HBDC_RESP_SLVERR));
      rd(HBDC_MON_OFFS, d, r);
      chk(32'(r), 32'(HBDC_RESP_OKAY));
      rdc(8'h00);
      $display("test bus done");
      finish_test();
   end
endmodule : hbdc_tb_top
